// File: cvr_pkg.sv
// Package with register map, field layout and types for the comparator block.
package cvr_pkg;
  // ----------------------------------------------------------------
  // Register map (word offsets on avs_address, not byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMP_CTRL = 4'h0;
  localparam logic [3:0] ADDR_REF_CTRL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h5;
  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam logic [5:0] CMP_CTRL_RST = 6'h07;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [3:0] PCFG_RST = 4'h0;
  localparam int BIT_REF_EN = 7;
  localparam int BIT_REF_OE = 6;
  localparam int BIT_REF_RNG = 5;
  localparam int BIT_REF_SRC = 4;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_CMP = 0;
  localparam int IRQ_WAKE = 1;
  localparam int BIT_SLEEP = 0;

  typedef struct packed {
    logic second_result_invert;
    logic first_result_invert;
    logic input_switch_select;
    logic [2:0] comparator_mode_field;
  } cvr_cmp_ctrl_s;

  typedef struct packed {
    logic ladder_power_enable;
    logic ladder_pin_output_enable;
    logic ladder_range_select;
    logic ladder_source_select;
    logic [3:0] ladder_level_code;
  } cvr_ref_ctrl_s;

  typedef enum logic [1:0] {
    CVR_RUN,
    CVR_SLEEP
  } cvr_pwr_e;
endpackage

// File: cvr_ctrl.sv
// Control logic for a dual comparator and its 16-level reference ladder.
// Function
// RULE1: Active comparator interrupt works and wakes sleep.
// RULE2: Software turns comparators off before sleeping.
// RULE3: Wake leaves comparator control unchanged.
// RULE4: Reset sets comparator mode to all ones.
// RULE5: Comparator pins reset to analog inputs.
// RULE6: Bit 7 powers reference ladder.
// RULE7: Bit 6 drives reference onto pin.
// RULE8: Pin output enable overrides direction latch.
// RULE9: Bit 5 selects low or high range.
// RULE10: High range spans quarter to three quarters.
// RULE11: Bit 4 selects external or supply source.
// RULE12: Bits 3-0 pick one of 16 taps.
// RULE13: Wake leaves reference control unchanged.
// RULE14: Reset clears reference control fields.
// RULE15: Reference independent of comparator mode.
// RULE16: Ladder controls are registered static outputs.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
module cvr_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic first_compare_raw,
  input wire logic second_compare_raw,
  input wire logic port_direction_latch,
  input wire logic [3:0] analog_port_config_field,
  output logic [2:0] comparator_mode_field,
  output logic input_switch_select,
  output logic first_compare_result,
  output logic second_compare_result,
  output logic [3:0] cmp_pin_analog,
  output cvr_pkg::cvr_ref_ctrl_s ladder_ctrl,
  output logic shared_pin_dir_input,
  output logic sleep_active,
  output logic wake_req,
  output logic irq
);
  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  cvr_pkg::cvr_cmp_ctrl_s cmp_q;
  cvr_pkg::cvr_ref_ctrl_s ref_q;
  cvr_pkg::cvr_pwr_e pwr_q;
  logic [cvr_pkg::IRQ_BITS-1:0] stat_q;
  logic [cvr_pkg::IRQ_BITS-1:0] en_q;
  logic [cvr_pkg::IRQ_BITS-1:0] ev;
  logic [cvr_pkg::IRQ_BITS-1:0] clr;
  logic ack_q;
  logic wr;
  logic rd;
  logic cmp_on;
  logic r1_q;
  logic r2_q;
  logic r1_d;
  logic r2_d;

  // One wait cycle per access: answer on the second edge of a request.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr = avs_write & ack_q & avs_byteenable[0];
  assign rd = avs_read & ack_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read | avs_write) & ~ack_q) begin
      unique case (avs_address)
        cvr_pkg::ADDR_CMP_CTRL:
          avs_readdata <= {24'h00_0000, r2_q, r1_q, cmp_q};
        cvr_pkg::ADDR_REF_CTRL:
          avs_readdata <= {24'h00_0000, ref_q};
        cvr_pkg::ADDR_IRQ_STAT:
          avs_readdata <= {30'h0000_0000, stat_q};
        cvr_pkg::ADDR_IRQ_EN:
          avs_readdata <= {30'h0000_0000, en_q};
        cvr_pkg::ADDR_SYS_CTRL:
          avs_readdata <= {31'h0000_0000, pwr_q == cvr_pkg::CVR_SLEEP};
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Comparator control
  // ----------------------------------------------------------------
  // Only bus writes change this register; sleep and wake never do.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_q <= cvr_pkg::cvr_cmp_ctrl_s'(cvr_pkg::CMP_CTRL_RST); // RULE4
    end else if (wr && avs_address == cvr_pkg::ADDR_CMP_CTRL) begin
      cmp_q <= cvr_pkg::cvr_cmp_ctrl_s'(avs_writedata[5:0]); // RULE3
    end
  end

  assign cmp_on = cmp_q.comparator_mode_field != cvr_pkg::MODE_OFF;
  assign comparator_mode_field = cmp_q.comparator_mode_field;
  assign input_switch_select = cmp_q.input_switch_select;
  assign r1_d = cmp_on & (first_compare_raw ^ cmp_q.first_result_invert);
  assign r2_d = cmp_on & (second_compare_raw ^ cmp_q.second_result_invert);

  // Results keep sampling in sleep, so a change can still wake.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r1_q <= 1'b0;
      r2_q <= 1'b0;
    end else begin
      r1_q <= r1_d; // RULE1
      r2_q <= r2_d;
    end
  end
  assign first_compare_result = r1_q;
  assign second_compare_result = r2_q;

  // Pins stay analog until the port configuration field releases them.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_pin_analog <= ~cvr_pkg::PCFG_RST; // RULE5
    end else begin
      cmp_pin_analog <= ~analog_port_config_field; // RULE5
    end
  end

  // ----------------------------------------------------------------
  // Reference control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= cvr_pkg::cvr_ref_ctrl_s'(cvr_pkg::REF_CTRL_RST); // RULE14
    end else if (wr && avs_address == cvr_pkg::ADDR_REF_CTRL) begin
      ref_q <= cvr_pkg::cvr_ref_ctrl_s'(avs_writedata[7:0]); // RULE13
    end
  end

  // Independent of the comparator mode; the ladder decodes the fields.
  assign ladder_ctrl = ref_q; // RULE6 RULE9 RULE10 RULE11 RULE12 RULE15 RULE16
  assign shared_pin_dir_input =
    ref_q.ladder_pin_output_enable | port_direction_latch; // RULE7 RULE8

  // ----------------------------------------------------------------
  // Sleep and interrupts
  // ----------------------------------------------------------------
  assign ev[cvr_pkg::IRQ_CMP] = (r1_d ^ r1_q) | (r2_d ^ r2_q);
  assign ev[cvr_pkg::IRQ_WAKE] = pwr_q == cvr_pkg::CVR_SLEEP && wake_req;
  assign clr = (wr && avs_address == cvr_pkg::ADDR_IRQ_CLR) ?
    avs_writedata[cvr_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev; // RULE1
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= '0;
    end else if (wr && avs_address == cvr_pkg::ADDR_IRQ_EN) begin
      en_q <= avs_writedata[cvr_pkg::IRQ_BITS-1:0];
    end
  end

  assign irq = |(stat_q & en_q);
  assign wake_req = stat_q[cvr_pkg::IRQ_CMP] & en_q[cvr_pkg::IRQ_CMP]; // RULE1

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q <= cvr_pkg::CVR_RUN;
    end else begin
      unique case (pwr_q)
        cvr_pkg::CVR_RUN:
          if (wr && avs_address == cvr_pkg::ADDR_SYS_CTRL &&
              avs_writedata[cvr_pkg::BIT_SLEEP]) begin
            pwr_q <= cvr_pkg::CVR_SLEEP;
          end
        cvr_pkg::CVR_SLEEP:
          if (wake_req) begin
            pwr_q <= cvr_pkg::CVR_RUN; // RULE1
          end
        default:
          pwr_q <= cvr_pkg::CVR_RUN;
      endcase
    end
  end
  assign sleep_active = pwr_q == cvr_pkg::CVR_SLEEP;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wake;
    @(posedge clk) disable iff (!rst_b)
      (sleep_active && wake_req) |=> !sleep_active;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // RULE1

  property p_cmp_hold;
    @(posedge clk) disable iff (!rst_b)
      !(wr && avs_address == cvr_pkg::ADDR_CMP_CTRL) |=> $stable(cmp_q);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("cmp changed"); // RULE3

  property p_ref_hold;
    @(posedge clk) disable iff (!rst_b)
      !(wr && avs_address == cvr_pkg::ADDR_REF_CTRL) |=> $stable(ref_q);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("ref changed"); // RULE13

  property p_oe;
    @(posedge clk) disable iff (!rst_b)
      ladder_ctrl.ladder_pin_output_enable |-> shared_pin_dir_input;
  endproperty
  a_oe: assert property (p_oe) else $error("oe lost"); // RULE8

  property p_off;
    @(posedge clk) disable iff (!rst_b)
      !cmp_on |=> !first_compare_result && !second_compare_result;
  endproperty
  a_off: assert property (p_off) else $error("off result"); // RULE4

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      (ev[cvr_pkg::IRQ_CMP] && en_q[cvr_pkg::IRQ_CMP]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RULE1

  // ----------------------------------------------------------------
  // Bus, result and sleep sequence checks
  // ----------------------------------------------------------------
  sequence s_new_req;
    (avs_read || avs_write) && !ack_q;
  endsequence

  sequence s_answer;
    !avs_waitrequest;
  endsequence

  sequence s_sleep_wake;
    sleep_active && wake_req;
  endsequence

  sequence s_sleep_write;
    wr && avs_address == cvr_pkg::ADDR_SYS_CTRL &&
      avs_writedata[cvr_pkg::BIT_SLEEP] && !sleep_active;
  endsequence

  // A new request waits one cycle and is answered on the next.
  property p_wait;
    @(posedge clk) disable iff (!rst_b)
      s_new_req |-> avs_waitrequest ##1 s_answer;
  endproperty
  a_wait: assert property (p_wait) // RULE16
    else $error("bus answer late");

  // Read data only move when a new request is first seen.
  property p_rd_hold;
    @(posedge clk) disable iff (!rst_b)
      !((avs_read || avs_write) && !ack_q) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) // RULE16
    else $error("read data moved");

  // A taken write to the comparator control lands in full.
  property p_cmp_write;
    @(posedge clk) disable iff (!rst_b)
      (wr && avs_address == cvr_pkg::ADDR_CMP_CTRL) |=>
        cmp_q == $past(avs_writedata[5:0]);
  endproperty
  a_cmp_write: assert property (p_cmp_write) // RULE3
    else $error("cmp write lost");

  // A taken write to the reference control reaches the ladder.
  property p_ref_write;
    @(posedge clk) disable iff (!rst_b)
      (wr && avs_address == cvr_pkg::ADDR_REF_CTRL) |=>
        ladder_ctrl == $past(avs_writedata[7:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) // RULE16
    else $error("ref write lost");

  // Without the output enable the pin follows its direction latch.
  property p_dir_latch;
    @(posedge clk) disable iff (!rst_b)
      !ladder_ctrl.ladder_pin_output_enable |->
        shared_pin_dir_input == port_direction_latch;
  endproperty
  a_dir_latch: assert property (p_dir_latch) // RULE7
    else $error("latch ignored");

  // The analog pin flags follow the inverted port configuration field.
  property p_pin_cfg;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> cmp_pin_analog == ~$past(analog_port_config_field);
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) // RULE5
    else $error("pin config lost");

  // An active first comparator keeps reporting its result.
  property p_result1;
    @(posedge clk) disable iff (!rst_b)
      cmp_on |=> first_compare_result ==
        $past(first_compare_raw ^ cmp_q.first_result_invert);
  endproperty
  a_result1: assert property (p_result1) // RULE1
    else $error("result one wrong");

  // An active second comparator keeps reporting its result.
  property p_result2;
    @(posedge clk) disable iff (!rst_b)
      cmp_on |=> second_compare_result ==
        $past(second_compare_raw ^ cmp_q.second_result_invert);
  endproperty
  a_result2: assert property (p_result2) // RULE1
    else $error("result two wrong");

  // A result change sets its status bit even against a clear.
  property p_set_wins;
    @(posedge clk) disable iff (!rst_b)
      ev[cvr_pkg::IRQ_CMP] |=> stat_q[cvr_pkg::IRQ_CMP];
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE1
    else $error("event lost");

  // A clear with no new event empties the status bit.
  property p_irq_clear;
    @(posedge clk) disable iff (!rst_b)
      (clr[cvr_pkg::IRQ_CMP] && !ev[cvr_pkg::IRQ_CMP]) |=>
        !stat_q[cvr_pkg::IRQ_CMP];
  endproperty
  a_irq_clear: assert property (p_irq_clear) // RULE1
    else $error("clear lost");

  // Waking from sleep records the wake in the status register.
  property p_wake_flag;
    @(posedge clk) disable iff (!rst_b)
      s_sleep_wake |=> stat_q[cvr_pkg::IRQ_WAKE];
  endproperty
  a_wake_flag: assert property (p_wake_flag) // RULE1
    else $error("wake not flagged");

  // A sleep command is obeyed on the next edge.
  property p_enter;
    @(posedge clk) disable iff (!rst_b)
      s_sleep_write |=> sleep_active;
  endproperty
  a_enter: assert property (p_enter) // RULE1
    else $error("sleep not entered");

  // Sleep lasts until an enabled comparator event wakes it.
  property p_sleep_hold;
    @(posedge clk) disable iff (!rst_b)
      (sleep_active && !wake_req) |=> sleep_active;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // RULE1
    else $error("spurious wake");

  // A disabled comparator interrupt can never end sleep.
  property p_wake_needs_en;
    @(posedge clk) disable iff (!rst_b)
      (sleep_active && !en_q[cvr_pkg::IRQ_CMP]) |=> sleep_active;
  endproperty
  a_wake_needs_en: assert property (p_wake_needs_en) // RULE1
    else $error("wake without enable");

  // A comparator mode change leaves the ladder settings alone.
  property p_mode_indep;
    @(posedge clk) disable iff (!rst_b)
      ($changed(comparator_mode_field) &&
        !(wr && avs_address == cvr_pkg::ADDR_REF_CTRL)) |=>
        $stable(ladder_ctrl);
  endproperty
  a_mode_indep: assert property (p_mode_indep) // RULE15
    else $error("ladder moved");
endmodule

// File: cvr_ladder_model.sv
// Behavioural model of the reference ladder and the two comparators.
module cvr_ladder_model (
  input cvr_pkg::cvr_ref_ctrl_s ladder_ctrl,
  input wire logic [6:0] vin,
  output logic raw1,
  output logic raw2
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] ref_lvl;

  // Levels are counted in ninety-sixths of the source span.
  always_comb begin
    if (!ladder_ctrl.ladder_power_enable) begin
      ref_lvl = 7'h00;
    end else if (ladder_ctrl.ladder_range_select) begin
      ref_lvl = 7'(7'h04 * ladder_ctrl.ladder_level_code);
    end else begin
      ref_lvl = 7'(7'h18 + 7'h03 * ladder_ctrl.ladder_level_code);
    end
  end

  assign raw1 = vin > ref_lvl;
  assign raw2 = vin < ref_lvl;
endmodule

// File: comparator_vref_control_tb.sv
// Self-checking testbench for the comparator and reference control block.
module comparator_vref_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, raw1, raw2, sel, res1, res2, dir_in, sleeping;
  logic wake, irq;
  logic [3:0] pcfg = 4'h0;
  logic latch = 1'h0;
  logic [3:0] pin_analog;
  logic [6:0] vin = 7'h00;
  logic [2:0] mode;
  cvr_pkg::cvr_ref_ctrl_s ladder;
  int failures = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  cvr_ctrl DUT (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_compare_raw(raw1), .second_compare_raw(raw2),
    .port_direction_latch(latch), .analog_port_config_field(pcfg),
    .comparator_mode_field(mode), .input_switch_select(sel),
    .first_compare_result(res1), .second_compare_result(res2),
    .cmp_pin_analog(pin_analog), .ladder_ctrl(ladder),
    .shared_pin_dir_input(dir_in), .sleep_active(sleeping),
    .wake_req(wake), .irq(irq));

  cvr_ladder_model PARTNER (.ladder_ctrl(ladder), .vin(vin), .raw1(raw1),
    .raw2(raw2));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n == 50) failures++;
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'h0, a, 32'h0);
    chk(q, {24'h0, exp});
  endtask

  task automatic t_reset;
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h07);
    rd(cvr_pkg::ADDR_REF_CTRL, 8'h00);
    chk(32'(ladder), 32'h0);
    chk(32'(pin_analog), 32'hF);
    @(posedge clk);
    pcfg <= 4'h5;
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    chk(32'(pin_analog), 32'hA);
  endtask

  task automatic t_ladder;
    wr(cvr_pkg::ADDR_REF_CTRL, 8'hD5);
    chk(32'(ladder), 32'hD5);
    chk(32'(dir_in), 32'h1);
    wr(cvr_pkg::ADDR_REF_CTRL, 8'h2A);
    chk(32'(ladder), 32'h2A);
    chk(32'(dir_in), 32'h0);
    @(posedge clk);
    latch <= 1'h1;
    @(negedge clk);
    chk(32'(dir_in), 32'h1);
    @(posedge clk);
    latch <= 1'h0;
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h07);
  endtask

  task automatic t_compare;
    @(posedge clk);
    vin <= 7'h28;
    wr(cvr_pkg::ADDR_REF_CTRL, 8'hA8);
    wr(cvr_pkg::ADDR_CMP_CTRL, 8'h06);
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h46);
    wr(cvr_pkg::ADDR_REF_CTRL, 8'h88);
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h86);
    wr(cvr_pkg::ADDR_CMP_CTRL, 8'h16);
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'hD6);
  endtask

  task automatic t_sleep;
    int n;
    wr(cvr_pkg::ADDR_REF_CTRL, 8'hA8);
    wr(cvr_pkg::ADDR_CMP_CTRL, 8'h06);
    wr(cvr_pkg::ADDR_IRQ_CLR, 8'h03);
    wr(cvr_pkg::ADDR_IRQ_EN, 8'h01);
    chk(32'(irq), 32'h0);
    wr(cvr_pkg::ADDR_SYS_CTRL, 8'h01);
    chk(32'(sleeping), 32'h1);
    @(posedge clk);
    vin <= 7'h0A;
    n = 0;
    while (irq !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(32'(irq), 32'h1);
    chk(32'(wake), 32'h1);
    @(negedge clk);
    chk(32'(sleeping), 32'h0);
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h86);
    rd(cvr_pkg::ADDR_REF_CTRL, 8'hA8);
    rd(cvr_pkg::ADDR_IRQ_STAT, 8'h03);
    wr(cvr_pkg::ADDR_IRQ_CLR, 8'h03);
    chk(32'(irq), 32'h0);
    wr(cvr_pkg::ADDR_IRQ_EN, 8'h00);
    @(posedge clk);
    vin <= 7'h28;
    rd(cvr_pkg::ADDR_IRQ_STAT, 8'h01);
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_sleep_off;
    wr(cvr_pkg::ADDR_CMP_CTRL, 8'h0F);
    chk(32'({sel, mode}), 32'hF);
    wr(cvr_pkg::ADDR_IRQ_CLR, 8'h03);
    wr(cvr_pkg::ADDR_IRQ_EN, 8'h01);
    wr(cvr_pkg::ADDR_SYS_CTRL, 8'h01);
    @(posedge clk);
    vin <= 7'h0A;
    repeat (3) @(negedge clk);
    chk(32'({sleeping, res2, res1}), 32'h4);
    rd(cvr_pkg::ADDR_CMP_CTRL, 8'h0F);
    wr(cvr_pkg::ADDR_CMP_CTRL, 8'h06);
    repeat (2) @(negedge clk);
    chk(32'({sleeping, wake}), 32'h1);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    t_reset;
    t_ladder;
    t_compare;
    t_sleep;
    t_sleep_off;
    report_and_stop;
  end

  // The tests need well under two thousand cycles.
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule
